// ---- src/upsc_pkg.sv ----
// Package: constants and types for the USB/ISDN power state control block
package upsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int REG_DELAY_US = 100;
  localparam int REG_DELAY_CYC = REG_DELAY_US * CLK_MHZ;
  localparam int CLK_DELAY_US = 4500;
  localparam int CLK_DELAY_CYC = CLK_DELAY_US * CLK_MHZ;
  localparam int IDLE_SUSP_US = 3000;
  localparam int IDLE_SUSP_CYC = IDLE_SUSP_US * CLK_MHZ;
  localparam int RESUME_MAX_US = 15000;
  localparam int RESUME_MAX_CYC = RESUME_MAX_US * CLK_MHZ;
  localparam int KDRIVE_US = 10000;
  localparam int KDRIVE_CYC = KDRIVE_US * CLK_MHZ;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FEATURE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DESC = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam int FEAT_OSC_KEEP = 3;
  localparam logic [7:0] FEATURE_RST = 8'h00;
  localparam int CMD_PUP = 0;
  localparam int CMD_PDN = 1;
  localparam int CMD_DEFAULT = 2;

  // ----------------------------------------------------------------
  // Descriptor coding
  // ----------------------------------------------------------------
  localparam logic [7:0] ATTR_BUS = 8'h80;
  localparam logic [7:0] ATTR_BUS_WAKE = 8'hA0;
  localparam logic [7:0] ATTR_SELF = 8'hC0;
  localparam logic [7:0] ATTR_SELF_WAKE = 8'hE0;
  localparam logic [7:0] PWR_100MA = 8'h32;
  localparam logic [7:0] PWR_150MA = 8'h96;
  localparam logic [7:0] PWR_250MA = 8'hF9;

  typedef enum logic [1:0] {
    UPSC_QUIET,
    UPSC_INACTIVE,
    UPSC_ACTIVE
  } upsc_smode_t;

  typedef enum logic [2:0] {
    UPSC_REG_WAIT,
    UPSC_CLK_WAIT,
    UPSC_RUN,
    UPSC_SUSPEND,
    UPSC_WAKE_K
  } upsc_pstate_t;

endpackage : upsc_pkg

// ---- src/upsc_power_ctrl.sv ----
// Power, clock, suspend and S interface mode control
//
// Overview of operation
// - Crystal clock feeds S interface, PLL fast.
// - USB bit clock recovered at fast clock.
// - Analog regulator enabled after fixed delay.
// - Pin reset waits before distributing clocks.
// - USB bus reset touches USB core and S interface mode, not application.
// - Restore-defaults request resets application state.
// - Suspend exit waits before distributing clocks on pin reset, or on resume or bus reset without keep-alive.
// - Suspend stops oscillator unless keep-alive set.
// - Attributes byte from supply and wakeup straps.
// - Max power byte from wakeup and power level straps.
// - Idle bus suspends even without reset.
// - Host resume restores activity within bound.
// - Wakeup drives K, recovery stays bounded.
// - Line detect triggers remote wakeup while suspended.
// - Quiet mode ignores everything, no clock.
// - Active mode leaves on power-down or suspend.
// - Inactive mode activates on line detect.
// - Suspended activation waits for resume completion.
// - Power-up primitive activates when configured.
// - Wakeup strap set starts in inactive.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module upsc_power_ctrl #(
  parameter int REG_CYC = upsc_pkg::REG_DELAY_CYC,
  parameter int CLK_CYC = upsc_pkg::CLK_DELAY_CYC,
  parameter int IDLE_CYC = upsc_pkg::IDLE_SUSP_CYC,
  parameter int KDRV_CYC = upsc_pkg::KDRIVE_CYC
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rstn,
  input wire logic pin_reset_n,
  // Straps
  input wire logic bus_power_select,
  input wire logic power_level_strap,
  input wire logic wakeup_strap,
  // USB side events
  input wire logic usb_bus_reset,
  input wire logic usb_bus_activity,
  input wire logic usb_resume,
  input wire logic usb_configured,
  // Line side
  input wire logic line_detect_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power and clock controls
  output logic analog_reg_en,
  output logic clk_dist_en,
  output logic osc_en,
  output logic pll_en,
  output logic usb_core_reset,
  output logic app_reset,
  output logic resume_k_drive,
  // Line interface macro
  output logic line_clk_en,
  output logic line_detect_en,
  output logic line_active,
  // Descriptor bytes
  output logic [7:0] cfg_attributes,
  output logic [7:0] cfg_max_power
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic strap_done_reg;
  logic bus_pwr_reg;
  logic pwr_lvl_reg;
  logic wake_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strap_done_reg <= 1'b0;
      bus_pwr_reg <= 1'b0;
      pwr_lvl_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      bus_pwr_reg <= bus_power_select;
      pwr_lvl_reg <= power_level_strap;
      wake_reg <= wakeup_strap;
    end
  end

  // ----------------------------------------------------------------
  // Descriptor coding
  // ----------------------------------------------------------------
  // attributes transcoding
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_attributes <= upsc_pkg::ATTR_BUS;
    end else begin
      unique case ({bus_pwr_reg, wake_reg})
        2'b10: cfg_attributes <= upsc_pkg::ATTR_BUS;
        2'b11: cfg_attributes <= upsc_pkg::ATTR_BUS_WAKE;
        2'b00: cfg_attributes <= upsc_pkg::ATTR_SELF;
        2'b01: cfg_attributes <= upsc_pkg::ATTR_SELF_WAKE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_max_power <= upsc_pkg::PWR_100MA;
    end else begin
      unique case ({wake_reg, pwr_lvl_reg})
        2'b00: cfg_max_power <= upsc_pkg::PWR_100MA;
        2'b11: cfg_max_power <= upsc_pkg::PWR_250MA;
        default: cfg_max_power <= upsc_pkg::PWR_150MA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic [7:0] feature_config_reg;
  logic default_req;
  logic pup_req;
  logic pdn_req;
  logic apb_wr;
  upsc_pkg::upsc_pstate_t pstate_reg;
  upsc_pkg::upsc_smode_t smode_reg;

  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr > upsc_pkg::ADDR_COMMAND);
  assign pup_req = apb_wr && paddr == upsc_pkg::ADDR_COMMAND && pwdata[upsc_pkg::CMD_PUP];
  assign pdn_req = apb_wr && paddr == upsc_pkg::ADDR_COMMAND && pwdata[upsc_pkg::CMD_PDN];
  assign default_req = apb_wr && paddr == upsc_pkg::ADDR_COMMAND
    && pwdata[upsc_pkg::CMD_DEFAULT];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      feature_config_reg <= upsc_pkg::FEATURE_RST;
    end else if (default_req) begin
      feature_config_reg <= upsc_pkg::FEATURE_RST;
    end else if (apb_wr && paddr == upsc_pkg::ADDR_FEATURE) begin
      feature_config_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        upsc_pkg::ADDR_FEATURE: prdata <= {24'h0, feature_config_reg};
        upsc_pkg::ADDR_STATUS: prdata <= {27'h0, smode_reg, pstate_reg};
        upsc_pkg::ADDR_DESC: prdata <= {16'h0, cfg_max_power, cfg_attributes};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power sequencer
  // ----------------------------------------------------------------
  logic [upsc_pkg::CNT_W-1:0] cnt_reg;
  logic [upsc_pkg::CNT_W-1:0] idle_reg;
  logic line_req;
  logic idle_hit;

  assign line_req = !line_detect_n;
  assign idle_hit = idle_reg >= upsc_pkg::CNT_W'(IDLE_CYC - 1);

  // bus idle counter, independent of reset history
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_reg <= '0;
    end else if (usb_bus_activity || pstate_reg != upsc_pkg::UPSC_RUN) begin
      idle_reg <= '0;
    end else if (!idle_hit) begin
      idle_reg <= idle_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pstate_reg <= upsc_pkg::UPSC_REG_WAIT;
      cnt_reg <= '0;
    end else if (!pin_reset_n) begin
      pstate_reg <= upsc_pkg::UPSC_CLK_WAIT;
      cnt_reg <= '0;
    end else begin
      unique case (pstate_reg)
        upsc_pkg::UPSC_REG_WAIT: begin
          if (cnt_reg == upsc_pkg::CNT_W'(REG_CYC - 1)) begin
            pstate_reg <= upsc_pkg::UPSC_CLK_WAIT;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        upsc_pkg::UPSC_CLK_WAIT: begin
          if (cnt_reg == upsc_pkg::CNT_W'(CLK_CYC - 1)) begin
            pstate_reg <= upsc_pkg::UPSC_RUN;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        upsc_pkg::UPSC_RUN: begin
          if (idle_hit && !usb_bus_activity) begin
            pstate_reg <= upsc_pkg::UPSC_SUSPEND;
          end
        end
        upsc_pkg::UPSC_SUSPEND: begin
          if (usb_resume || usb_bus_reset) begin
            pstate_reg <= feature_config_reg[upsc_pkg::FEAT_OSC_KEEP]
              ? upsc_pkg::UPSC_RUN : upsc_pkg::UPSC_CLK_WAIT;
            cnt_reg <= '0;
          end else if (wake_reg && line_req && smode_reg == upsc_pkg::UPSC_INACTIVE) begin
            pstate_reg <= upsc_pkg::UPSC_WAKE_K;
            cnt_reg <= '0;
          end
        end
        upsc_pkg::UPSC_WAKE_K: begin
          if (cnt_reg == upsc_pkg::CNT_W'(KDRV_CYC - 1)) begin
            pstate_reg <= upsc_pkg::UPSC_RUN;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: pstate_reg <= upsc_pkg::UPSC_REG_WAIT;
      endcase
    end
  end

  assign osc_en = pstate_reg != upsc_pkg::UPSC_REG_WAIT
    && !(pstate_reg == upsc_pkg::UPSC_SUSPEND
    && !feature_config_reg[upsc_pkg::FEAT_OSC_KEEP]);
  assign pll_en = osc_en;
  assign analog_reg_en = pstate_reg != upsc_pkg::UPSC_REG_WAIT;
  assign clk_dist_en = pstate_reg == upsc_pkg::UPSC_RUN || pstate_reg == upsc_pkg::UPSC_WAKE_K;
  assign resume_k_drive = pstate_reg == upsc_pkg::UPSC_WAKE_K;
  // bus reset reaches USB core reset, not the application reset
  assign usb_core_reset = usb_bus_reset;
  // Pulse lasts only the access phase of the command write
  assign app_reset = default_req;

  // ----------------------------------------------------------------
  // S interface mode machine
  // ----------------------------------------------------------------
  logic pend_reg;
  logic suspended;
  assign suspended = pstate_reg == upsc_pkg::UPSC_SUSPEND || pstate_reg == upsc_pkg::UPSC_WAKE_K;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      smode_reg <= upsc_pkg::UPSC_QUIET;
      pend_reg <= 1'b0;
    end else if (!strap_done_reg || !pin_reset_n || usb_bus_reset || default_req) begin
      smode_reg <= (strap_done_reg ? wake_reg : wakeup_strap)
        ? upsc_pkg::UPSC_INACTIVE : upsc_pkg::UPSC_QUIET;
      pend_reg <= 1'b0;
    end else begin
      unique case (smode_reg)
        upsc_pkg::UPSC_QUIET: smode_reg <= upsc_pkg::UPSC_QUIET;
        upsc_pkg::UPSC_INACTIVE: begin
          if (line_req && suspended) begin
            pend_reg <= 1'b1;
          end else if (pend_reg && pstate_reg == upsc_pkg::UPSC_RUN) begin
            smode_reg <= upsc_pkg::UPSC_ACTIVE;
            pend_reg <= 1'b0;
          end else if (line_req && !suspended) begin
            smode_reg <= upsc_pkg::UPSC_ACTIVE;
          end else if (pup_req && usb_configured) begin
            smode_reg <= upsc_pkg::UPSC_ACTIVE;
          end
        end
        upsc_pkg::UPSC_ACTIVE: begin
          if (pdn_req || suspended) begin
            smode_reg <= upsc_pkg::UPSC_INACTIVE;
          end
        end
        default: smode_reg <= upsc_pkg::UPSC_QUIET;
      endcase
    end
  end

  assign line_clk_en = smode_reg != upsc_pkg::UPSC_QUIET && osc_en;
  assign line_detect_en = smode_reg == upsc_pkg::UPSC_INACTIVE;
  assign line_active = smode_reg == upsc_pkg::UPSC_ACTIVE;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_quiet_no_clock: assert property (@(posedge mclk) disable iff (!rstn)
    smode_reg == upsc_pkg::UPSC_QUIET |-> !line_clk_en && !line_detect_en)
    else $error("quiet mode feeds line macro");
  chk_suspend_osc_off: assert property (@(posedge mclk) disable iff (!rstn)
    pstate_reg == upsc_pkg::UPSC_SUSPEND && !feature_config_reg[upsc_pkg::FEAT_OSC_KEEP]
    |-> !osc_en) else $error("oscillator runs in suspend");
  chk_active_suspend: assert property (@(posedge mclk) disable iff (!rstn)
    smode_reg == upsc_pkg::UPSC_ACTIVE && suspended && pin_reset_n && !usb_bus_reset
    && !default_req |=> smode_reg == upsc_pkg::UPSC_INACTIVE)
    else $error("active survives suspend");
  chk_pend_no_active: assert property (@(posedge mclk) disable iff (!rstn)
    suspended && smode_reg != upsc_pkg::UPSC_ACTIVE && !pup_req
    |=> smode_reg != upsc_pkg::UPSC_ACTIVE) else $error("activated while suspended");
  chk_attr_coding: assert property (@(posedge mclk) disable iff (!rstn)
    strap_done_reg && $stable(wake_reg) |=> cfg_attributes[5] == wake_reg
    && cfg_attributes[6] == !bus_pwr_reg) else $error("attributes wrong");
  chk_power_coding: assert property (@(posedge mclk) disable iff (!rstn)
    strap_done_reg && wake_reg && pwr_lvl_reg |=> cfg_max_power == upsc_pkg::PWR_250MA)
    else $error("max power wrong");
  chk_bus_reset_core: assert property (@(posedge mclk) disable iff (!rstn)
    usb_bus_reset && !default_req |-> usb_core_reset && !app_reset)
    else $error("bus reset hits application");
  chk_clk_after_reg: assert property (@(posedge mclk) disable iff (!rstn)
    pstate_reg == upsc_pkg::UPSC_REG_WAIT |-> !analog_reg_en && !clk_dist_en)
    else $error("regulator early");

endmodule : upsc_power_ctrl

// ---- testbench/upsc_usb_host.sv ----
// Host or hub model facing the power state control block
`timescale 1ns/1ns
module upsc_usb_host #(
  parameter int REPLY_DLY = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bench requests
  input wire logic go_idle,
  input wire logic bus_rst_req,
  // Device side
  input wire logic resume_k_drive,
  output logic usb_bus_reset,
  output logic usb_bus_activity,
  output logic usb_resume,
  output logic usb_configured
);
  logic idle_q;
  logic woken;
  int kcnt;
  // ---
  // Bus reset and enumeration
  // ---
  // configured after reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      usb_bus_reset <= 1'b0;
      usb_configured <= 1'b0;
    end else begin
      usb_bus_reset <= bus_rst_req;
      if (bus_rst_req) begin
        usb_configured <= 1'b0;
      end else if (usb_bus_reset) begin
        usb_configured <= 1'b1;
      end
    end
  end
  // ---
  // Frames, suspend and resume
  // ---
  // answer to remote K
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= 1'b0;
      woken <= 1'b0;
      kcnt <= 0;
      usb_resume <= 1'b0;
      usb_bus_activity <= 1'b0;
    end else begin
      idle_q <= go_idle;
      usb_resume <= 1'b0;
      usb_bus_activity <= !go_idle || woken;
      kcnt <= (go_idle && resume_k_drive && !woken) ? kcnt + 1 : 0;
      if (!go_idle) begin
        woken <= 1'b0;
      end
      // Resume only once: a late answer must not repeat it
      if (idle_q && !go_idle && !woken) begin
        usb_resume <= 1'b1;
      end
      if (kcnt == REPLY_DLY) begin
        usb_resume <= 1'b1;
        woken <= 1'b1;
      end
    end
  end
endmodule : upsc_usb_host

// ---- testbench/upsc_power_ctrl_bench.sv ----
// Self-checking bench for the power state control block
`timescale 1ns/1ns
module upsc_power_ctrl_bench;
  // ---
  // Signals
  // ---
  localparam int RC = 10, CC = 20, IC = 30, KC = 15;
  typedef struct packed {logic w; logic p; logic b; logic [7:0] a; logic [7:0] m;} upsc_row_t;
  upsc_row_t rows [8];
  logic mclk = 1'b0, rstn = 1'b0, pin_reset_n = 1'b1, go_idle = 1'b0, bus_rst_req = 1'b0;
  logic bus_power_select = 1'b1, power_level_strap = 1'b0, wakeup_strap = 1'b0;
  logic line_detect_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, analog_reg_en, clk_dist_en, osc_en, pll_en, usb_core_reset;
  logic app_reset, resume_k_drive, line_clk_en, line_detect_en, line_active;
  logic usb_bus_reset, usb_bus_activity, usb_resume, usb_configured;
  logic [7:0] cfg_attributes, cfg_max_power;
  int bad_count = 0, n_checks = 0, n, t0, n_app = 0;

  upsc_power_ctrl #(.REG_CYC(RC), .CLK_CYC(CC), .IDLE_CYC(IC), .KDRV_CYC(KC)) dut (
    .mclk, .rstn, .pin_reset_n, .bus_power_select, .power_level_strap, .wakeup_strap,
    .usb_bus_reset, .usb_bus_activity, .usb_resume, .usb_configured, .line_detect_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .analog_reg_en,
    .clk_dist_en, .osc_en, .pll_en, .usb_core_reset, .app_reset, .resume_k_drive,
    .line_clk_en, .line_detect_en, .line_active, .cfg_attributes, .cfg_max_power);
  upsc_usb_host #(.REPLY_DLY(4)) host (.mclk, .rstn, .go_idle, .bus_rst_req,
    .resume_k_drive, .usb_bus_reset, .usb_bus_activity, .usb_resume, .usb_configured);

  always #5 mclk = ~mclk;

  // Restore pulse stands only in the access phase, so count it at the edge
  always @(posedge mclk) begin
    if (app_reset === 1'b1) begin
      n_app++;
    end
  end

  // ---
  // Tasks
  // ---
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // The master never assumes a latency; the watchdog ends a hang
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic sig(input int i);
    case (i)
      0: return clk_dist_en;
      1: return osc_en;
      2: return line_active;
      3: return resume_k_drive;
      4: return analog_reg_en;
      default: return app_reset;
    endcase
  endfunction : sig
  task automatic wait_for(input int i, input logic v, input int lim);
    n = 0;
    #1;
    while (sig(i) !== v && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk1(sig(i), v);
  endtask : wait_for
  task automatic rst(input logic [2:0] s);
    @(posedge mclk);
    rstn <= 1'b0;
    {wakeup_strap, power_level_strap, bus_power_select} <= s;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
  endtask : rst
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // ---
  // Watchdog
  // ---
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run();
  end

  // ---
  // Tests
  // ---
  initial begin
    rows = '{'{1'b0, 1'b0, 1'b1, upsc_pkg::ATTR_BUS, upsc_pkg::PWR_100MA},
      '{1'b0, 1'b1, 1'b1, upsc_pkg::ATTR_BUS, upsc_pkg::PWR_150MA},
      '{1'b1, 1'b0, 1'b1, upsc_pkg::ATTR_BUS_WAKE, upsc_pkg::PWR_150MA},
      '{1'b1, 1'b1, 1'b1, upsc_pkg::ATTR_BUS_WAKE, upsc_pkg::PWR_250MA},
      '{1'b0, 1'b0, 1'b0, upsc_pkg::ATTR_SELF, upsc_pkg::PWR_100MA},
      '{1'b0, 1'b1, 1'b0, upsc_pkg::ATTR_SELF, upsc_pkg::PWR_150MA},
      '{1'b1, 1'b0, 1'b0, upsc_pkg::ATTR_SELF_WAKE, upsc_pkg::PWR_150MA},
      '{1'b1, 1'b1, 1'b0, upsc_pkg::ATTR_SELF_WAKE, upsc_pkg::PWR_250MA}};
    for (int i = 0; i < 8; i++) begin
      rst({rows[i].w, rows[i].p, rows[i].b});
      repeat (3) @(posedge mclk);
      #1;
      chk32(32'(cfg_attributes), 32'(rows[i].a));
      chk32(32'(cfg_max_power), 32'(rows[i].m));
      apb(1'b0, upsc_pkg::ADDR_STATUS, 32'h0);
      chk32(32'(rd[4:3]), 32'(rows[i].w));
    end
    // Power-up timing from a fresh reset
    rst(3'b111);
    wait_for(4, 1'b1, RC + 8);
    chk1(n >= RC - 1, 1'b1);
    t0 = n;
    wait_for(0, 1'b1, CC + 20);
    chk1(n + t0 >= CC - 2, 1'b1);
    @(posedge mclk);
    pin_reset_n <= 1'b0;
    @(posedge mclk);
    pin_reset_n <= 1'b1;
    wait_for(0, 1'b0, 3);
    wait_for(0, 1'b1, CC + 10);
    chk1(n >= CC - 3, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk1(err, 1'b1);
    apb(1'b0, upsc_pkg::ADDR_FEATURE, 32'h0);
    chk32(rd, 32'(upsc_pkg::FEATURE_RST));
    // Bus reset keeps the application side
    apb(1'b1, upsc_pkg::ADDR_FEATURE, 32'h8);
    @(posedge mclk);
    bus_rst_req <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk1(usb_core_reset, 1'b1);
    chk1(app_reset, 1'b0);
    @(posedge mclk);
    bus_rst_req <= 1'b0;
    apb(1'b0, upsc_pkg::ADDR_FEATURE, 32'h0);
    chk32(rd, 32'h8);
    apb(1'b1, upsc_pkg::ADDR_COMMAND, 32'h4);
    #1;
    chk32(32'(n_app), 32'h1);
    apb(1'b0, upsc_pkg::ADDR_FEATURE, 32'h0);
    chk32(rd, 32'(upsc_pkg::FEATURE_RST));
    apb(1'b1, upsc_pkg::ADDR_COMMAND, 32'h1);
    wait_for(2, 1'b1, 5);
    apb(1'b1, upsc_pkg::ADDR_COMMAND, 32'h2);
    wait_for(2, 1'b0, 5);
    chk1(line_detect_en, 1'b1);
    @(posedge mclk);
    line_detect_n <= 1'b0;
    wait_for(2, 1'b1, 5);
    @(posedge mclk);
    line_detect_n <= 1'b1;
    go_idle <= 1'b1;
    wait_for(1, 1'b0, IC + 20);
    chk1(n >= IC - 2, 1'b1);
    chk1(pll_en, 1'b0);
    @(posedge mclk);
    #1;
    chk1(line_active, 1'b0);
    @(posedge mclk);
    go_idle <= 1'b0;
    wait_for(0, 1'b1, CC + 20);
    chk1(n >= CC - 2, 1'b1);
    // Remote wakeup from the line while suspended
    @(posedge mclk);
    go_idle <= 1'b1;
    wait_for(1, 1'b0, IC + 20);
    @(posedge mclk);
    line_detect_n <= 1'b0;
    wait_for(3, 1'b1, 6);
    chk1(line_active, 1'b0);
    wait_for(2, 1'b1, KC + CC + 30);
    @(posedge mclk);
    line_detect_n <= 1'b1;
    go_idle <= 1'b0;
    // Keep-alive holds the oscillator through suspend
    apb(1'b1, upsc_pkg::ADDR_FEATURE, 32'h8);
    @(posedge mclk);
    go_idle <= 1'b1;
    repeat (IC + 20) @(posedge mclk);
    #1;
    chk1(osc_en, 1'b1);
    apb(1'b0, upsc_pkg::ADDR_STATUS, 32'h0);
    chk32(32'(rd[2:0]), 32'(upsc_pkg::UPSC_SUSPEND));
    @(posedge mclk);
    go_idle <= 1'b0;
    wait_for(0, 1'b1, CC + 20);
    @(posedge mclk);
    {wakeup_strap, power_level_strap, bus_power_select} <= 3'b000;
    repeat (3) @(posedge mclk);
    #1;
    chk32(32'(cfg_attributes), 32'(upsc_pkg::ATTR_BUS_WAKE));
    chk32(32'(cfg_max_power), 32'(upsc_pkg::PWR_250MA));
    // Quiet mode ignores both activation paths
    rst(3'b001);
    wait_for(0, 1'b1, RC + CC + 20);
    // Configure first, so that only quiet mode can refuse the power-up
    @(posedge mclk);
    bus_rst_req <= 1'b1;
    @(posedge mclk);
    bus_rst_req <= 1'b0;
    apb(1'b1, upsc_pkg::ADDR_COMMAND, 32'h1);
    @(posedge mclk);
    line_detect_n <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk1(line_active, 1'b0);
    chk1(line_detect_en, 1'b0);
    chk1(line_clk_en, 1'b0);
    complete_run();
  end
endmodule : upsc_power_ctrl_bench
